// ### hdl/tltr_trip_regs.sv
module tltr_trip_regs (
	input  wire logic        sys_clk,      // 100 MHz
	input  wire logic        reset_n,      // async, active low
	input  wire logic        clk_en,       // freezes all state when low
	input  wire logic [3:0]  reg_addr,     // register index
	input  wire logic        reg_wr,       // write strobe
	input  wire logic        reg_rd,       // read strobe
	input  wire logic [15:0] reg_wdata,    // write data
	output logic      [15:0] reg_rdata,    // read data, registered
	input  wire logic        window_lock_bit,   // config bit 6
	input  wire logic        critical_lock_bit, // config bit 7
	input  wire logic        alert_enable,      // config event enable
	input  wire logic [1:0]  hysteresis_select, // config hysteresis
	input  wire logic [15:0] temp_value,   // measured temp, bits 12:1
	input  wire logic        temp_valid,   // new conversion pulse
	output logic      [15:0] upper_trip_value,    // stored upper
	output logic      [15:0] lower_trip_value,    // stored lower
	output logic      [15:0] critical_trip_value, // stored critical
	output logic             upper_flag,   // above upper, registered
	output logic             lower_flag,   // below lower, registered
	output logic             crit_flag,    // above critical, registered
	output logic             alert_out     // gated alert, active high
);

	// decoded writes
	wire logic        hit_upper;
	wire logic        hit_lower;
	wire logic        hit_crit;
	wire logic        wr_upper;
	wire logic        wr_lower;
	wire logic        wr_crit;
	wire logic [15:0] wdata_clean;       // reserved bits dropped
	wire logic [15:0] rd_mux;            // selected read value

	// signed compare operands in eighth degrees, 14 bits
	wire logic signed [13:0] t_s;        // measured
	wire logic signed [13:0] up_s;       // upper trip
	wire logic signed [13:0] lo_s;       // lower trip
	wire logic signed [13:0] cr_s;       // critical trip
	wire logic signed [13:0] hyst_s;     // hysteresis, eighths
	logic        [4:0]  hyst_q;          // hysteresis, quarters

	// next flag values
	wire logic nxt_upper;
	wire logic nxt_lower;
	wire logic nxt_crit;
	wire logic nxt_alert;

	// state
	logic [15:0] upper_ff;
	logic [15:0] lower_ff;
	logic [15:0] crit_ff;
	logic [15:0] rdata_ff;
	logic        upper_f_ff;
	logic        lower_f_ff;
	logic        crit_f_ff;
	logic        alert_ff;

	// address decode
	assign hit_upper = (reg_addr == tltr_pkg::UPPER_ADDR);
	assign hit_lower = (reg_addr == tltr_pkg::LOWER_ADDR);
	assign hit_crit  = (reg_addr == tltr_pkg::CRIT_ADDR);

	// locked writes still complete, they just do not store
	assign wr_upper = reg_wr & hit_upper & ~window_lock_bit;
	assign wr_lower = reg_wr & hit_lower & ~window_lock_bit;
	assign wr_crit  = reg_wr & hit_crit & ~critical_lock_bit
		& ~window_lock_bit;

	// keep sign and magnitude, drop reserved bits
	assign wdata_clean = reg_wdata & tltr_pkg::WRITE_MASK;

	// read select, unmapped index reads zero
	assign rd_mux = hit_upper ? upper_ff :
		hit_lower ? lower_ff :
		hit_crit  ? crit_ff  : 16'h0000;

	// trip bits 12:2 sit over temperature bits 12:2; extend to eighths
	// sign copied twice so a concat of 14 bits keeps negatives negative
	assign t_s  = {{2{temp_value[tltr_pkg::SIGN_POS]}},
		temp_value[tltr_pkg::FIELD_HI:1]};
	assign up_s = {{2{upper_ff[tltr_pkg::SIGN_POS]}},
		upper_ff[tltr_pkg::FIELD_HI:tltr_pkg::FIELD_LO], 1'b0};
	assign lo_s = {{2{lower_ff[tltr_pkg::SIGN_POS]}},
		lower_ff[tltr_pkg::FIELD_HI:tltr_pkg::FIELD_LO], 1'b0};
	assign cr_s = {{2{crit_ff[tltr_pkg::SIGN_POS]}},
		crit_ff[tltr_pkg::FIELD_HI:tltr_pkg::FIELD_LO], 1'b0};

	// hysteresis lookup in quarter degrees
	always_comb begin
		case (hysteresis_select)
			tltr_pkg::HYST_NONE: hyst_q = 5'h00;
			tltr_pkg::HYST_1P5:  hyst_q = tltr_pkg::HYST_Q_1P5;
			tltr_pkg::HYST_3P0:  hyst_q = tltr_pkg::HYST_Q_3P0;
			tltr_pkg::HYST_6P0:  hyst_q = tltr_pkg::HYST_Q_6P0;
			default:             hyst_q = 5'h00;
		endcase
	end
	assign hyst_s = $signed({8'h00, hyst_q, 1'b0});

	// set on rise above, hold until at or below point minus hysteresis
	assign nxt_upper = upper_f_ff ? (t_s > (up_s - hyst_s))
		: (t_s > up_s);
	// below lower sets, at or above clears, no hysteresis on rise
	assign nxt_lower = (t_s < lo_s);
	assign nxt_crit  = crit_f_ff ? (t_s > (cr_s - hyst_s))
		: (t_s > cr_s);

	// alert gated by enable
	assign nxt_alert = alert_enable
		& (nxt_upper | nxt_lower | nxt_crit);

	// trip register storage
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			upper_ff <= tltr_pkg::TRIP_RESET;
			lower_ff <= tltr_pkg::TRIP_RESET;
			crit_ff  <= tltr_pkg::TRIP_RESET;
		end else if (clk_en) begin
			if (wr_upper) begin
				upper_ff <= wdata_clean;
			end
			if (wr_lower) begin
				lower_ff <= wdata_clean;
			end
			if (wr_crit) begin
				crit_ff <= wdata_clean;
			end
		end
	end

	// registered read data
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_ff <= 16'h0000;
		end else if (clk_en && reg_rd) begin
			rdata_ff <= rd_mux;
		end
	end

	// compare flags refresh on each conversion
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			upper_f_ff <= 1'b0;
			lower_f_ff <= 1'b0;
			crit_f_ff  <= 1'b0;
		end else if (clk_en && temp_valid) begin
			upper_f_ff <= nxt_upper;
			lower_f_ff <= nxt_lower;
			crit_f_ff  <= nxt_crit;
		end
	end

	// alert follows flags, drops on the next enabled clock edge when disabled
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			alert_ff <= 1'b0;
		end else if (clk_en) begin
			if (!alert_enable) begin
				alert_ff <= 1'b0;
			end else if (temp_valid) begin
				alert_ff <= nxt_alert;
			end else begin
				alert_ff <= upper_f_ff | lower_f_ff | crit_f_ff;
			end
		end
	end

	// outputs straight from flops
	assign reg_rdata           = rdata_ff;
	assign upper_trip_value    = upper_ff;
	assign lower_trip_value    = lower_ff;
	assign critical_trip_value = crit_ff;
	assign upper_flag          = upper_f_ff;
	assign lower_flag          = lower_f_ff;
	assign crit_flag           = crit_f_ff;
	assign alert_out           = alert_ff;

endmodule

// ### hdl/tltr_pkg.sv
package tltr_pkg;
	// register indices on the internal register port
	localparam logic [3:0]  UPPER_ADDR    = 4'h2;
	localparam logic [3:0]  LOWER_ADDR    = 4'h3;
	localparam logic [3:0]  CRIT_ADDR     = 4'h4;
	// trip register layout
	localparam int          SIGN_POS      = 12;
	localparam int          FIELD_HI      = 12;
	localparam int          FIELD_LO      = 2;
	localparam logic [15:0] WRITE_MASK    = 16'h1FFC;
	localparam logic [15:0] TRIP_RESET    = 16'h0000;
	// hysteresis codes, in quarter degrees (bit 2 weight)
	localparam logic [1:0]  HYST_NONE     = 2'h0;
	localparam logic [1:0]  HYST_1P5      = 2'h1;
	localparam logic [1:0]  HYST_3P0      = 2'h2;
	localparam logic [1:0]  HYST_6P0      = 2'h3;
	localparam logic [4:0]  HYST_Q_1P5    = 5'h06;
	localparam logic [4:0]  HYST_Q_3P0    = 5'h0C;
	localparam logic [4:0]  HYST_Q_6P0    = 5'h18;
endpackage

// ### sim/tltr_checker.sv
module tltr_checker (
	input wire logic        sys_clk,
	input wire logic        reset_n,
	input wire logic        clk_en,
	input wire logic        reg_wr,
	input wire logic        temp_valid,
	input wire logic        window_lock_bit,
	input wire logic        critical_lock_bit,
	input wire logic        alert_enable,
	input wire logic        upper_flag,
	input wire logic        lower_flag,
	input wire logic        alert_out,
	input wire logic [3:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] temp_value,
	input wire logic [15:0] upper_trip_value,
	input wire logic [15:0] lower_trip_value,
	input wire logic [15:0] critical_trip_value
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// unlocked write strobe and signed views of temp and trips
	wire               wr_ok = clk_en && reg_wr && !window_lock_bit;
	wire               tv_ok = clk_en && temp_valid;
	wire signed [12:0] tv    = temp_value[12:0];
	wire signed [12:0] up    = upper_trip_value[12:0];
	wire signed [12:0] lo    = lower_trip_value[12:0];
	a_rsvd_zero:
		assert property (((upper_trip_value | lower_trip_value |
			critical_trip_value) & 16'hE003) == 16'h0) else $error("rsvd set");
	a_upper_wr:
		assert property (wr_ok && reg_addr == 4'h2 |=> upper_trip_value ==
			($past(reg_wdata) & 16'h1FFC)) else $error("upper write");
	a_lower_wr:
		assert property (wr_ok && reg_addr == 4'h3 |=> lower_trip_value ==
			($past(reg_wdata) & 16'h1FFC)) else $error("lower write");
	a_crit_wr:
		assert property (wr_ok && !critical_lock_bit && reg_addr == 4'h4 |=>
			critical_trip_value == ($past(reg_wdata) & 16'h1FFC))
			else $error("crit write");
	a_win_lock:
		assert property (window_lock_bit |=> $stable(upper_trip_value) &&
			$stable(lower_trip_value) && $stable(critical_trip_value))
			else $error("window lock");
	a_crit_lock:
		assert property (critical_lock_bit |=> $stable(critical_trip_value))
			else $error("crit lock");
	a_alert_off:
		assert property (clk_en && !alert_enable |=> !alert_out)
			else $error("alert while off");
	a_upper_set:
		assert property (tv_ok && tv > up |=> upper_flag) else $error("upper");
	a_lower_set:
		assert property (tv_ok && tv < lo |=> lower_flag) else $error("lower");
endmodule
bind tltr_trip_regs tltr_checker u_chk (.*);

// ### sim/tltr_host.sv
module tltr_host (
	input  wire logic        sys_clk,
	input  wire logic [15:0] reg_rdata,
	output logic      [3:0]  reg_addr,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic      [15:0] reg_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
	// one write cycle, lines inverted on release
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk) #1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
		@(posedge sys_clk) #1 {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
	endtask
	// one read cycle, data taken after the read edge
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge sys_clk) #1 {reg_addr, reg_rd} = {a, 1'b1};
		@(posedge sys_clk) #1 {reg_addr, reg_rd} = {~a, 1'b0};
		d = reg_rdata;
	endtask
endmodule

// ### sim/temp_limit_trip_registers_tb.sv
module temp_limit_trip_registers_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 0, reset_n = 0, clk_en = 1, temp_valid = 0;
	logic window_lock_bit = 0, critical_lock_bit = 0, alert_enable = 0;
	logic [1:0]  hysteresis_select = 2'h0;
	logic [15:0] temp_value = 16'h0, rv, reg_rdata, reg_wdata;
	logic [15:0] upper_trip_value, lower_trip_value, critical_trip_value;
	logic [15:0] hq [4] = '{16'h0, 16'h18, 16'h30, 16'h60}; // raw hysteresis
	logic [3:0]  reg_addr;
	logic        reg_wr, reg_rd, upper_flag, lower_flag, crit_flag, alert_out;
	int          mismatches = 0, n_checks = 0;
	always #5 sys_clk = ~sys_clk;
	tltr_host      u_host (.*);
	tltr_trip_regs u_dut (.*);
	task automatic chk(input string n, input logic [15:0] e, g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic rchk(input logic [3:0] a, input logic [15:0] e);
		u_host.rd(a, rv);
		chk("rdata", e, rv);
	endtask
	// one conversion, then flags {crit,upper,lower} and alert
	task automatic temp(input logic [15:0] t, input logic [2:0] e);
		@(posedge sys_clk) #1 {temp_value, temp_valid} = {t, 1'b1};
		@(posedge sys_clk) #1 temp_valid = 0;
		@(posedge sys_clk) #1;
		chk("flags", {13'h0, e}, {13'h0, crit_flag, upper_flag, lower_flag});
		chk("alert", {15'h0, alert_enable & |e}, {15'h0, alert_out});
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		#1 reset_n = 1;
		for (int a = 2; a < 5; a++) rchk(4'(a), 16'h0);
		for (int a = 2; a < 5; a++) u_host.wr(4'(a), 16'hFFFF);
		for (int a = 2; a < 6; a++) rchk(4'(a), a < 5 ? 16'h1FFC : 16'h0);
		alert_enable = 1;
		u_host.wr(4'h2, 16'h0550);
		u_host.wr(4'h4, 16'h0550);
		for (int h = 0; h < 4; h++) begin
			hysteresis_select = 2'(h);
			temp(16'h0552, 3'h6);
			temp(16'h0552 - hq[h], 3'h6);
			temp(16'h0550 - hq[h], 3'h0);
		end
		temp(16'h1FF0, 3'h1);
		temp(16'h1FFC, 3'h0);
		temp(16'h0560, 3'h6);
		alert_enable = 0;
		repeat (2) @(posedge sys_clk);
		#1;
		chk("alert", 16'h0, {15'h0, alert_out});
		window_lock_bit = 1;
		for (int a = 2; a < 5; a++) u_host.wr(4'(a), 16'h0);
		rchk(4'h2, 16'h0550);
		rchk(4'h3, 16'h1FFC);
		rchk(4'h4, 16'h0550);
		{window_lock_bit, critical_lock_bit} = 2'b01;
		u_host.wr(4'h4, 16'h0);
		u_host.wr(4'h3, 16'h1234);
		rchk(4'h4, 16'h0550);
		rchk(4'h3, 16'h1234);
		clk_en = 0;
		u_host.wr(4'h2, 16'h0100);
		clk_en = 1;
		rchk(4'h2, 16'h0550);
		final_report();
	end
	initial begin
		#100000;
		mismatches++;
		final_report();
	end
endmodule
